// ---- frpl_bank.sv ----
// frpl_bank: fault response, minimum on-time, balancing and max-duty
// registers with the serious-fault latch that they steer.
// assumes the serial command decoder on clk_i; detector and enable pins
// are asynchronous and synchronised here.
//
// Overview of operation
// R1 - boost low-side short with bit 5 clear: fail line low, PWM latched off
// R2 - with bit 5 set, fail line stays released; second-level responses decide
// R3 - bit 6 clear: buck high bus short pulls fail low and latches PWM off
// R4 - bit 7 clear: boost high bus short pulls fail low and latches PWM off
// R5 - bits 6 or 7 set: no fail pull for that fault; defer to responses
// R6 - min on-time code 00..11 gives 340, 280, 220, 180 ns
// R7 - balance bits: 00 none, 01 within, 10 between, 11 both
// R8 - max duty register: three-bit field, rest reserved, resets to zero
// R9 - max duty codes give 91.7, 95.8, 87.5, 83.3, 79.2, 75.0 percent
// R10 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module frpl_bank
  import frpl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register command port
  input wire frpl_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic cmd_hit_o,
  // converter state and detector pins
  input wire logic boost_mode_i,
  input wire frpl_fault_s fault_i,
  input wire logic enable_i,
  input wire logic pwm_run_en_i,
  // open-drain system fail line, active low
  output logic system_fail_line_o,
  output logic system_fail_line_oe_o,
  // shutdown and deferred fault to second-level responses
  output logic pwm_stop_o,
  output logic fault_defer_o,
  // pulse limits and balancing
  output logic [7:0] min_on_cycles_o,
  output logic bal_within_o,
  output logic bal_between_o,
  output logic [9:0] max_duty_permille_o
);

  logic [7:0] fault_resp_ff;
  logic [7:0] min_on_bal_ff;
  logic [7:0] max_duty_ff;
  frpl_fault_s flt_meta_ff;
  frpl_fault_s flt_sync_ff;
  logic [1:0] en_meta_ff;
  logic [1:0] en_sync_ff;
  logic [1:0] en_prev_ff;
  logic latch_ff;
  logic nxt_latch;
  logic trip;
  logic defer;
  logic restart;

  // register writes; reserved bits never store
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_resp_ff <= FRPL_RST_FAULT_RESP;
      min_on_bal_ff <= FRPL_RST_MIN_ON_BAL;
      max_duty_ff <= FRPL_RST_MAX_DUTY;
    end else if (req_i.wr) begin
      unique case (req_i.cmd)
        FRPL_CMD_FAULT_RESP:
          fault_resp_ff <= req_i.wdata & FRPL_MASK_FAULT_RESP; // R10
        FRPL_CMD_MIN_ON_BAL:
          min_on_bal_ff <= req_i.wdata & FRPL_MASK_MIN_ON_BAL; // R10
        FRPL_CMD_MAX_DUTY:
          max_duty_ff <= req_i.wdata & FRPL_MASK_MAX_DUTY; // R8
        default: ;
      endcase
    end
  end

  // read answers one cycle after the request; unknown codes read zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      cmd_hit_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      cmd_hit_o <= (req_i.rd || req_i.wr) &&
                   (req_i.cmd == FRPL_CMD_FAULT_RESP ||
                    req_i.cmd == FRPL_CMD_MIN_ON_BAL ||
                    req_i.cmd == FRPL_CMD_MAX_DUTY);
      if (req_i.rd) begin
        unique case (req_i.cmd)
          FRPL_CMD_FAULT_RESP: rdata_o <= fault_resp_ff;
          FRPL_CMD_MIN_ON_BAL: rdata_o <= min_on_bal_ff;
          FRPL_CMD_MAX_DUTY: rdata_o <= max_duty_ff;
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // two-stage synchronisers for the asynchronous detector pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flt_meta_ff <= '0;
      flt_sync_ff <= '0;
    end else begin
      flt_meta_ff <= fault_i;
      flt_sync_ff <= flt_meta_ff;
    end
  end

  // enables reset low: only a falling edge restarts, so a pin that is
  // already high at release cannot look like a toggle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_meta_ff <= 2'h0;
      en_sync_ff <= 2'h0;
      en_prev_ff <= 2'h0;
    end else begin
      en_meta_ff <= {pwm_run_en_i, enable_i};
      en_sync_ff <= en_meta_ff;
      en_prev_ff <= en_sync_ff;
    end
  end

  // detectors only count in the mode they belong to
  always_comb begin
    trip = 1'b0;
    defer = 1'b0;
    if (boost_mode_i && flt_sync_ff.ls_short_boost) begin
      if (!fault_resp_ff[FRPL_BIT_LS_BOOST]) begin
        trip = 1'b1; // R1
      end else begin
        defer = 1'b1; // R2
      end
    end
    if (!boost_mode_i && flt_sync_ff.hv_short_buck) begin
      if (!fault_resp_ff[FRPL_BIT_HV_BUCK]) begin
        trip = 1'b1; // R3
      end else begin
        defer = 1'b1; // R5
      end
    end
    if (boost_mode_i && flt_sync_ff.hv_short_boost) begin
      if (!fault_resp_ff[FRPL_BIT_HV_BOOST]) begin
        trip = 1'b1; // R4
      end else begin
        defer = 1'b1; // R5
      end
    end
  end

  // a disable edge on either enable restarts; a trip in that cycle wins
  assign restart = |(en_prev_ff & ~en_sync_ff);

  always_comb begin
    nxt_latch = latch_ff;
    if (restart) nxt_latch = 1'b0;
    if (trip) nxt_latch = 1'b1; // R1
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_ff <= 1'b0;
      pwm_stop_o <= 1'b0;
      system_fail_line_o <= 1'b0;
      system_fail_line_oe_o <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
      pwm_stop_o <= nxt_latch; // R1
      system_fail_line_o <= 1'b0;
      system_fail_line_oe_o <= nxt_latch; // R5
    end
  end

  // deferred faults are not latched; they follow the detector level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_defer_o <= 1'b0;
    end else begin
      fault_defer_o <= defer; // R2
    end
  end

  // minimum on-time decode, in core clock cycles
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      min_on_cycles_o <= FRPL_MIN_ON_CYC_0;
    end else begin
      unique case (min_on_bal_ff[FRPL_POS_MIN_ON +: 2])
        2'h0: min_on_cycles_o <= FRPL_MIN_ON_CYC_0; // R6
        2'h1: min_on_cycles_o <= FRPL_MIN_ON_CYC_1;
        2'h2: min_on_cycles_o <= FRPL_MIN_ON_CYC_2;
        2'h3: min_on_cycles_o <= FRPL_MIN_ON_CYC_3;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bal_within_o <= 1'b0;
      bal_between_o <= 1'b0;
    end else begin
      bal_within_o <= min_on_bal_ff[FRPL_POS_BAL_IN]; // R7
      bal_between_o <= min_on_bal_ff[FRPL_POS_BAL_OUT]; // R7
    end
  end

  // unassigned duty codes fall back to the default limit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      max_duty_permille_o <= FRPL_DUTY_CODE0;
    end else begin
      unique case (max_duty_ff[FRPL_POS_DUTY +: 3])
        3'h0: max_duty_permille_o <= FRPL_DUTY_CODE0; // R9
        3'h1: max_duty_permille_o <= FRPL_DUTY_CODE1;
        3'h2: max_duty_permille_o <= FRPL_DUTY_CODE2;
        3'h3: max_duty_permille_o <= FRPL_DUTY_CODE3;
        3'h4: max_duty_permille_o <= FRPL_DUTY_CODE4;
        3'h5: max_duty_permille_o <= FRPL_DUTY_CODE5;
        default: max_duty_permille_o <= FRPL_DUTY_CODE0;
      endcase
    end
  end

endmodule : frpl_bank
`default_nettype wire

// ---- frpl_bank_asserts.sv ----
// frpl_bank_asserts: port checks for the fault response bank
// assumes one clock and async active-low reset; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module frpl_bank_asserts
  import frpl_pkg::*;
(
  // clock, reset and command port
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire frpl_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic cmd_hit_o,
  // converter side
  input wire logic boost_mode_i,
  input wire frpl_fault_s fault_i,
  input wire logic enable_i,
  input wire logic pwm_run_en_i,
  input wire logic system_fail_line_o,
  input wire logic system_fail_line_oe_o,
  input wire logic pwm_stop_o,
  input wire logic fault_defer_o,
  input wire logic [7:0] min_on_cycles_o,
  input wire logic bal_within_o,
  input wire logic bal_between_o,
  input wire logic [9:0] max_duty_permille_o
);
  logic [7:0] sfr_ff;
  wire logic ls_t = fault_i.ls_short_boost && boost_mode_i;
  wire logic hb_t = fault_i.hv_short_buck && !boost_mode_i;
  wire logic hs_t = fault_i.hv_short_boost && boost_mode_i;
  wire logic bd_wr = req_i.wr && req_i.cmd == FRPL_CMD_FAULT_RESP;
  wire logic mapped = req_i.cmd inside {[8'hBD:8'hBF]};
  // shadow of the response byte, needed to know which way a fault goes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) sfr_ff <= 8'h00;
    else if (bd_wr) sfr_ff <= req_i.wdata;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_ls(b); (ls_t && sfr_ff[5] == b) [*3]; endsequence
  sequence s_hb(b); (hb_t && sfr_ff[6] == b) [*3]; endsequence
  sequence s_hs(b); (hs_t && sfr_ff[7] == b) [*3]; endsequence
  property p_rd; req_i.rd |=> rvalid_o; endproperty
  property p_unmap;
    req_i.rd && !mapped |=> rdata_o == 8'h00 && !cmd_hit_o;
  endproperty
  property p_ls; s_ls(0) |=> system_fail_line_oe_o && pwm_stop_o; endproperty
  property p_lsd; s_ls(1) |=> fault_defer_o; endproperty
  property p_hb; s_hb(0) |=> system_fail_line_oe_o && pwm_stop_o; endproperty
  property p_hs; s_hs(0) |=> system_fail_line_oe_o && pwm_stop_o; endproperty
  property p_hd; s_hb(1) or s_hs(1) |=> fault_defer_o; endproperty
  property p_oe; system_fail_line_oe_o |-> pwm_stop_o && !system_fail_line_o;
  endproperty
  property p_min; min_on_cycles_o inside {8'h44, 8'h38, 8'h2C, 8'h24};
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_ls: assert property (p_ls) else $error("ls trip missed");
  a_lsd: assert property (p_lsd) else $error("ls defer missed");
  a_hb: assert property (p_hb) else $error("buck trip missed");
  a_hs: assert property (p_hs) else $error("boost trip missed");
  a_hd: assert property (p_hd) else $error("hv defer missed");
  a_oe: assert property (p_oe) else $error("fail without stop");
  a_min: assert property (p_min) else $error("bad min on");
endmodule : frpl_bank_asserts
bind frpl_bank frpl_bank_asserts frpl_bank_asserts_i (.*);
`default_nettype wire

// ---- frpl_bank_tb.sv ----
// frpl_bank_tb: self-checking bench for the fault response bank
// assumes frpl_host drives the byte port; 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module frpl_bank_tb;
  import frpl_pkg::*;
  logic clk_i, resetn_i, boost, en, run, rvalid, hit, fl, oe, stop, defer;
  logic bw, bb;
  frpl_req_s req;
  frpl_fault_s flt;
  logic [7:0] rdata, min_on, d;
  logic [8:0] expq[$];
  logic [7:0] cm[3] = '{8'hBD, 8'hBE, 8'hBF};
  logic [7:0] mk[3] = '{8'hF7, 8'h0F, 8'h07};
  logic [7:0] mt[4] = '{8'h44, 8'h38, 8'h2C, 8'h24};
  logic [9:0] duty;
  logic [9:0] dt[8] = '{10'h395, 10'h3BE, 10'h36B, 10'h341, 10'h318,
    10'h2EE, 10'h395, 10'h395};
  logic [31:0] rng = 32'h39;
  int miscompares = 0;
  int num_checks = 0;
  frpl_host frpl_host_i (.clk_i(clk_i), .req_o(req));
  frpl_bank frpl_bank_i (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .cmd_hit_o(hit),
    .boost_mode_i(boost), .fault_i(flt), .enable_i(en),
    .pwm_run_en_i(run), .system_fail_line_o(fl),
    .system_fail_line_oe_o(oe), .pwm_stop_o(stop), .fault_defer_o(defer),
    .min_on_cycles_o(min_on), .bal_within_o(bw), .bal_between_o(bb),
    .max_duty_permille_o(duty));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // read answer: command hit flag above the data byte
  task automatic chk_rd(input logic [8:0] e);
    chk({1'b0, hit, rdata}, {1'b0, e});
  endtask : chk_rd
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xorshift = v ^ (v << 5);
  endfunction : xorshift
  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    rng = xorshift(rng);
    expq.push_back({(c inside {FRPL_CMD_FAULT_RESP, FRPL_CMD_MIN_ON_BAL,
      FRPL_CMD_MAX_DUTY}), e});
    frpl_host_i.xfer(1'b0, c, rng[7:0]);
  endtask : rd
  // one trip: fault held four edges, then restart by an enable drop
  task automatic trip(input logic [7:0] r, input logic m,
    input frpl_fault_s f, input logic [3:0] e);
    frpl_host_i.xfer(1'b1, 8'hBD, r);
    boost = m;
    flt = f;
    tk(4);
    chk({6'h00, fl, oe, stop, defer}, {6'h00, e});
    flt = '0;
    if (m) run = 0;
    else en = 0;
    tk(1);
    run = 1;
    en = 1;
    tk(6);
    chk({6'h00, fl, oe, stop, defer}, 10'h000);
  endtask : trip
  // looked at mid-cycle, away from the edge that launches the answer
  always @(negedge clk_i) if (rvalid === 1'b1) begin
    if (expq.size() == 0) chk(10'h001, 10'h000);
    else chk_rd(expq.pop_front());
  end
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial begin
    {resetn_i, boost, flt, en, run} = 7'h03;
    repeat (12) @(posedge clk_i);
    #1 resetn_i = 1;
    chk({min_on, bb, bw}, {8'h44, 2'h0});
    chk(duty, 10'h395);
    for (int i = 0; i < 3; i++) rd(cm[i], 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = rng[15:8];
      frpl_host_i.xfer(1'b1, cm[i % 3], d);
      rd(cm[i % 3], d & mk[i % 3]);
    end
    frpl_host_i.xfer(1'b1, 8'hC0, 8'hFF);
    rd(8'hC0, 8'h00);
    for (int k = 0; k < 16; k++) begin
      frpl_host_i.xfer(1'b1, 8'hBE, 8'(k));
      tk(2);
      chk({min_on, bb, bw}, {mt[k % 4], k[3], k[2]});
    end
    for (int k = 0; k < 8; k++) begin
      frpl_host_i.xfer(1'b1, 8'hBF, 8'(k));
      tk(2);
      chk(duty, dt[k]);
    end
    trip(8'h00, 1'b0, 3'b010, 4'b0110);
    trip(8'h00, 1'b1, 3'b001, 4'b0110);
    trip(8'h00, 1'b1, 3'b100, 4'b0110);
    trip(8'h00, 1'b0, 3'b100, 4'b0000);
    trip(8'h20, 1'b1, 3'b100, 4'b0001);
    trip(8'h40, 1'b0, 3'b010, 4'b0001);
    trip(8'h80, 1'b1, 3'b001, 4'b0001);
    for (int i = 0; i < 20 && expq.size() > 0; i++) tk(1);
    if (expq.size() > 0) miscompares++;
    complete_run();
  end
endmodule : frpl_bank_tb
`default_nettype wire

// ---- frpl_host.sv ----
// frpl_host: host side of the byte command port
// assumes clk_i from the bench; the bench calls xfer for each byte
`timescale 1ns/1ps
`default_nettype none
module frpl_host
  import frpl_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request to the bank
  output var frpl_req_s req_o
);
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    req_o = {w, !w, c, d};
    @(posedge clk_i);
    #1;
    // released fields flip so a stale byte never looks valid
    req_o = {2'h0, ~c, ~d};
  endtask : xfer
endmodule : frpl_host
`default_nettype wire

// ---- frpl_pkg.sv ----
// frpl_pkg: constants and carriers for the fault response and pulse limit
// register bank; shared by the design and its verification.
package frpl_pkg;

  // command codes, as the serial command decoder presents them
  localparam logic [7:0] FRPL_CMD_FAULT_RESP = 8'hBD;
  localparam logic [7:0] FRPL_CMD_MIN_ON_BAL = 8'hBE;
  localparam logic [7:0] FRPL_CMD_MAX_DUTY = 8'hBF;

  // reset values
  localparam logic [7:0] FRPL_RST_FAULT_RESP = 8'h00;
  localparam logic [7:0] FRPL_RST_MIN_ON_BAL = 8'h00;
  localparam logic [7:0] FRPL_RST_MAX_DUTY = 8'h00;

  // writable bit masks; zeros are reserved bits
  localparam logic [7:0] FRPL_MASK_FAULT_RESP = 8'hF7;
  localparam logic [7:0] FRPL_MASK_MIN_ON_BAL = 8'h0F;
  localparam logic [7:0] FRPL_MASK_MAX_DUTY = 8'h07;

  // field positions
  localparam int FRPL_BIT_LS_BOOST = 5;
  localparam int FRPL_BIT_HV_BUCK = 6;
  localparam int FRPL_BIT_HV_BOOST = 7;
  localparam int FRPL_POS_MIN_ON = 0;
  localparam int FRPL_POS_BAL_IN = 2;
  localparam int FRPL_POS_BAL_OUT = 3;
  localparam int FRPL_POS_DUTY = 0;

  // minimum on-time in ns, and cycles at the core clock (rounded up)
  localparam int FRPL_CLK_PERIOD_PS = 5000;
  localparam int FRPL_MIN_ON_NS_0 = 340;
  localparam int FRPL_MIN_ON_NS_1 = 280;
  localparam int FRPL_MIN_ON_NS_2 = 220;
  localparam int FRPL_MIN_ON_NS_3 = 180;
  localparam logic [7:0] FRPL_MIN_ON_CYC_0 = 8'((FRPL_MIN_ON_NS_0 * 1000 +
    FRPL_CLK_PERIOD_PS - 1) / FRPL_CLK_PERIOD_PS);
  localparam logic [7:0] FRPL_MIN_ON_CYC_1 = 8'((FRPL_MIN_ON_NS_1 * 1000 +
    FRPL_CLK_PERIOD_PS - 1) / FRPL_CLK_PERIOD_PS);
  localparam logic [7:0] FRPL_MIN_ON_CYC_2 = 8'((FRPL_MIN_ON_NS_2 * 1000 +
    FRPL_CLK_PERIOD_PS - 1) / FRPL_CLK_PERIOD_PS);
  localparam logic [7:0] FRPL_MIN_ON_CYC_3 = 8'((FRPL_MIN_ON_NS_3 * 1000 +
    FRPL_CLK_PERIOD_PS - 1) / FRPL_CLK_PERIOD_PS);

  // maximum duty in tenths of a percent
  localparam logic [9:0] FRPL_DUTY_CODE0 = 10'd917;
  localparam logic [9:0] FRPL_DUTY_CODE1 = 10'd958;
  localparam logic [9:0] FRPL_DUTY_CODE2 = 10'd875;
  localparam logic [9:0] FRPL_DUTY_CODE3 = 10'd833;
  localparam logic [9:0] FRPL_DUTY_CODE4 = 10'd792;
  localparam logic [9:0] FRPL_DUTY_CODE5 = 10'd750;

  // serious fault detector outputs
  typedef struct packed {
    logic ls_short_boost;
    logic hv_short_buck;
    logic hv_short_boost;
  } frpl_fault_s;

  // register bank command port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } frpl_req_s;

endpackage : frpl_pkg
